// [include/dspad_pkg.sv]
// constants and types for the operand addressing decoder
package dspad_pkg;
    localparam int ACC_W = 32;
    localparam int WORD_W = 16;
    localparam int RAM_AW = 8;
    localparam int RAM_DEPTH = 256;
    localparam int NUM_AUX = 2;
    // apb byte offsets
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_ACC_HI = 8'h04;
    localparam logic [7:0] OFF_ACC_LO = 8'h08;
    localparam logic [7:0] OFF_AUX0 = 8'h0C;
    localparam logic [7:0] OFF_AUX1 = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_RAM_ADDR = 8'h18;
    localparam logic [7:0] OFF_RAM_DATA = 8'h1C;
    localparam logic [7:0] OFF_TREG = 8'h20;
    localparam logic [7:0] OFF_PREG = 8'h24;
    // status fields
    localparam int ST_PAGE = 0;
    localparam int ST_ARP = 1;
    localparam int ST_ILLEGAL = 2;
    localparam int ST_BUSY = 3;
    localparam int ST_PORT_LSB = 4;
    localparam int ST_IO_DIR = 7;
    localparam int ST_IO_SEEN = 8;
    // instruction word fields
    localparam int MODE_BIT = 7;
    localparam int IND_INC = 5;
    localparam int IND_DEC = 4;
    localparam int IND_KEEP = 3;
    localparam int IND_NEXT = 0;
    localparam int DIV_SHIFT = 15;
    localparam logic [31:0] ACC_RST = 32'h0000_0000;
    localparam logic [15:0] WORD_RST = 16'h0000;
    typedef enum logic [4:0] {
        OP_ADD = 5'b00000, OP_SUB = 5'b00001, OP_LAC = 5'b00010,
        OP_STORE_HIGH_SHIFT_OP = 5'b00011, OP_STORE_LOW_OP = 5'b00100, OP_ADD_HIGH_OP = 5'b00101,
        OP_ADD_UNSIGNED_OP = 5'b00110, OP_SUBTRACT_HIGH_OP = 5'b00111, OP_SUBTRACT_UNSIGNED_OP = 5'b01000,
        OP_DIVIDE_STEP_OP = 5'b01001, OP_CLEAR_LOAD_HIGH_OP = 5'b01010, OP_CLEAR_LOAD_LOW_OP = 5'b01011,
        OP_AND = 5'b01100, OP_OR = 5'b01101, OP_XOR = 5'b01110,
        OP_LDP = 5'b01111, OP_LAR = 5'b10000, OP_SAR = 5'b10001,
        OP_MAR = 5'b10010, OP_LOAD_AUX_IMMEDIATE_OP = 5'b10011, OP_LOAD_ACCUM_IMMEDIATE_OP = 5'b10100,
        OP_LOAD_PAGE_IMMEDIATE_OP = 5'b10101, OP_MULTIPLY_IMMEDIATE_OP = 5'b10110, OP_ABS = 5'b10111,
        OP_ZAC = 5'b11000, OP_IO = 5'b11001, OP_ILLEGAL = 5'b11010
    } dspad_op_e;
endpackage

// [src/dspad_core.sv]
// operand addressing and accumulator instruction decoder with apb access
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module dspad_core (
    input wire logic pclk, // 50 MHz bus clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr // apb error, unmapped address
);
    import dspad_pkg::*;

    // operand shifter: sign fill above, zero fill below
    function automatic logic [ACC_W-1:0] shl_sext(input logic [WORD_W-1:0] d,
                                                  input logic [4:0] s);
        logic [ACC_W-1:0] ext;
        ext = {{(ACC_W-WORD_W){d[WORD_W-1]}}, d};
        return ext << s;
    endfunction

    function automatic dspad_op_e op_decode(input logic [15:0] w);
        dspad_op_e op;
        op = OP_ILLEGAL;
        casez (w)
            16'b0000_????_????_????: op = OP_ADD;
            16'b0001_????_????_????: op = OP_SUB;
            16'b0010_????_????_????: op = OP_LAC;
            16'b0011_000?_????_????: op = OP_SAR;
            16'b0011_100?_????_????: op = OP_LAR;
            16'b0100_????_????_????: op = OP_IO;
            16'b0101_0000_????_????: op = OP_STORE_LOW_OP;
            16'b0101_1???_????_????: op = OP_STORE_HIGH_SHIFT_OP;
            16'b0110_0000_????_????: op = OP_ADD_HIGH_OP;
            16'b0110_0001_????_????: op = OP_ADD_UNSIGNED_OP;
            16'b0110_0010_????_????: op = OP_SUBTRACT_HIGH_OP;
            16'b0110_0011_????_????: op = OP_SUBTRACT_UNSIGNED_OP;
            16'b0110_0100_????_????: op = OP_DIVIDE_STEP_OP;
            16'b0110_0101_????_????: op = OP_CLEAR_LOAD_HIGH_OP;
            16'b0110_0110_????_????: op = OP_CLEAR_LOAD_LOW_OP;
            16'b0110_1000_????_????: op = OP_MAR;
            16'b0110_1110_0000_000?: op = OP_LOAD_PAGE_IMMEDIATE_OP;
            16'b0110_1111_????_????: op = OP_LDP;
            16'b0111_000?_????_????: op = OP_LOAD_AUX_IMMEDIATE_OP;
            16'b0111_1000_????_????: op = OP_XOR;
            16'b0111_1001_????_????: op = OP_AND;
            16'b0111_1010_????_????: op = OP_OR;
            16'b0111_1110_????_????: op = OP_LOAD_ACCUM_IMMEDIATE_OP;
            16'b0111_1111_1000_1000: op = OP_ABS;
            16'b0111_1111_1000_1001: op = OP_ZAC;
            16'b100?_????_????_????: op = OP_MULTIPLY_IMMEDIATE_OP;
            default: op = OP_ILLEGAL;
        endcase
        return op;
    endfunction

    logic [WORD_W-1:0] data_ram [RAM_DEPTH];
    logic [ACC_W-1:0] accum_reg;
    logic [WORD_W-1:0] aux_file [NUM_AUX];
    logic aux_select_pointer;
    logic page_ptr;
    logic [15:0] instr_q;
    logic exec_pending;
    logic illegal_flag;
    logic [2:0] port_select_field;
    logic io_dir;
    logic io_seen;
    logic [RAM_AW-1:0] ram_ptr;
    logic [WORD_W-1:0] treg;
    logic [ACC_W-1:0] preg;

    // apb decode
    wire bus_req = psel & penable;
    wire take = bus_req & pready;
    wire wr_take = take & pwrite;
    wire addr_hit = (paddr == OFF_INSTR) | (paddr == OFF_ACC_HI)
        | (paddr == OFF_ACC_LO) | (paddr == OFF_AUX0) | (paddr == OFF_AUX1)
        | (paddr == OFF_STATUS) | (paddr == OFF_RAM_ADDR)
        | (paddr == OFF_RAM_DATA) | (paddr == OFF_TREG) | (paddr == OFF_PREG);
    wire wr_instr = wr_take & (paddr == OFF_INSTR);
    wire wr_ram_addr = wr_take & (paddr == OFF_RAM_ADDR);
    wire wr_ram_data = wr_take & (paddr == OFF_RAM_DATA);
    wire wr_treg = wr_take & (paddr == OFF_TREG);

    // instruction fields
    wire [15:0] w = instr_q;
    wire dspad_op_e op = op_decode(instr_q);
    wire ind = w[MODE_BIT];
    wire aux_r = w[8];
    wire [RAM_AW-1:0] dir_addr = {page_ptr, w[6:0]};
    wire [WORD_W-1:0] aux_reg_zero = aux_file[0];
    wire [WORD_W-1:0] aux_reg_one = aux_file[1];
    wire [WORD_W-1:0] cur_aux = aux_select_pointer ? aux_reg_one : aux_reg_zero;
    wire [RAM_AW-1:0] opnd_addr = ind ? cur_aux[RAM_AW-1:0] : dir_addr;
    wire [WORD_W-1:0] mem_word = data_ram[opnd_addr];
    wire mem_ref = !(op inside {OP_LOAD_AUX_IMMEDIATE_OP, OP_LOAD_ACCUM_IMMEDIATE_OP, OP_LOAD_PAGE_IMMEDIATE_OP, OP_MULTIPLY_IMMEDIATE_OP,
                                OP_ABS, OP_ZAC, OP_ILLEGAL});
    wire ind_mod = exec_pending & mem_ref & ind;
    wire step_inc = ind_mod & w[IND_INC];
    wire step_dec = ind_mod & w[IND_DEC];

    // shifter and alu operands, all combinational for single-cycle issue
    wire [ACC_W-1:0] sh_opnd = shl_sext(mem_word, {1'b0, w[11:8]});
    wire [ACC_W-1:0] hi_opnd = {mem_word, 16'h0000};
    wire [ACC_W-1:0] zx_opnd = {16'h0000, mem_word};
    wire [ACC_W-1:0] acc_shx = accum_reg << w[10:8];
    wire [ACC_W-1:0] div_diff = accum_reg - shl_sext(mem_word, 5'(DIV_SHIFT));
    wire [ACC_W-1:0] acc_neg = ACC_W'(32'h0) - accum_reg;
    wire [WORD_W-1:0] k_imm = {{3{w[12]}}, w[12:0]};
    wire signed [ACC_W-1:0] mpy_prod = $signed(treg) * $signed(k_imm);

    logic [ACC_W-1:0] next_acc;
    logic [ACC_W-1:0] next_preg;
    logic next_page;
    logic ram_we;
    logic [WORD_W-1:0] ram_wd;
    logic ld_aux;
    logic [WORD_W-1:0] ld_aux_val;
    logic next_illegal;

    // one instruction per issue cycle; every case completes here
    always_comb begin
        next_acc = accum_reg;
        next_preg = preg;
        next_page = page_ptr;
        ram_we = 1'b0;
        ram_wd = WORD_RST;
        ld_aux = 1'b0;
        ld_aux_val = WORD_RST;
        next_illegal = 1'b0;
        unique case (op)
            OP_ADD: next_acc = accum_reg + sh_opnd;
            OP_SUB: next_acc = accum_reg - sh_opnd;
            OP_LAC: next_acc = sh_opnd;
            OP_STORE_HIGH_SHIFT_OP: begin
                ram_we = 1'b1;
                ram_wd = acc_shx[31:16];
            end
            OP_STORE_LOW_OP: begin
                ram_we = 1'b1;
                ram_wd = accum_reg[15:0];
            end
            OP_ADD_HIGH_OP: next_acc = accum_reg + hi_opnd;
            OP_ADD_UNSIGNED_OP: next_acc = accum_reg + zx_opnd;
            OP_SUBTRACT_HIGH_OP: next_acc = accum_reg - hi_opnd;
            OP_SUBTRACT_UNSIGNED_OP: next_acc = accum_reg - zx_opnd;
            OP_DIVIDE_STEP_OP: begin
                if (!div_diff[ACC_W-1]) begin
                    next_acc = {div_diff[ACC_W-2:0], 1'b1};
                end else begin
                    next_acc = {accum_reg[ACC_W-2:0], 1'b0};
                end
            end
            OP_CLEAR_LOAD_HIGH_OP: next_acc = hi_opnd;
            OP_CLEAR_LOAD_LOW_OP: next_acc = zx_opnd;
            OP_AND: next_acc = accum_reg & zx_opnd;
            OP_OR: next_acc = accum_reg | zx_opnd;
            OP_XOR: next_acc = accum_reg ^ zx_opnd;
            OP_LDP: next_page = mem_word[0];
            OP_LAR: begin
                ld_aux = 1'b1;
                ld_aux_val = mem_word;
            end
            OP_SAR: begin
                ram_we = 1'b1;
                ram_wd = aux_file[aux_r];
            end
            OP_MAR: next_acc = accum_reg;
            OP_LOAD_AUX_IMMEDIATE_OP: begin
                ld_aux = 1'b1;
                ld_aux_val = {8'h00, w[7:0]};
            end
            OP_LOAD_ACCUM_IMMEDIATE_OP: next_acc = {24'h00_0000, w[7:0]};
            OP_LOAD_PAGE_IMMEDIATE_OP: next_page = w[0];
            OP_MULTIPLY_IMMEDIATE_OP: next_preg = mpy_prod;
            OP_ABS: next_acc = accum_reg[ACC_W-1] ? acc_neg : accum_reg;
            OP_ZAC: next_acc = ACC_RST;
            OP_IO: next_acc = accum_reg;
            OP_ILLEGAL: next_illegal = 1'b1;
        endcase
    end

    // auxiliary registers: load, or step the current one
    genvar gi;
    for (gi = 0; gi < NUM_AUX; gi++) begin : g_aux
        wire is_cur = (aux_select_pointer == 1'(gi));
        wire is_ld = exec_pending & ld_aux & (aux_r == 1'(gi));
        logic [WORD_W-1:0] next_aux;
        // a load of the current register wins over its step
        always_comb begin
            next_aux = aux_file[gi];
            if (is_ld) begin
                next_aux = ld_aux_val;
            end else if (is_cur & step_inc & ~step_dec) begin
                next_aux = aux_file[gi] + 16'h0001;
            end else if (is_cur & step_dec & ~step_inc) begin
                next_aux = aux_file[gi] - 16'h0001;
            end
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                aux_file[gi] <= WORD_RST;
            end else begin
                aux_file[gi] <= next_aux;
            end
        end
    end

    // pointer change in the same cycle as the indirect operation
    wire arp_load = ind_mod & ~w[IND_KEEP];
    wire next_arp = arp_load ? w[IND_NEXT] : aux_select_pointer;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accum_reg <= ACC_RST;
            preg <= ACC_RST;
            page_ptr <= 1'b0;
            aux_select_pointer <= 1'b0;
            illegal_flag <= 1'b0;
        end else if (exec_pending) begin
            accum_reg <= next_acc;
            preg <= next_preg;
            page_ptr <= next_page;
            aux_select_pointer <= next_arp;
            illegal_flag <= next_illegal;
        end
    end

    // io instructions record their port, direction and a seen flag; indirect ones also update the current aux register and pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_select_field <= 3'h0;
            io_dir <= 1'b0;
            io_seen <= 1'b0;
        end else if (exec_pending && op == OP_IO) begin
            port_select_field <= w[10:8];
            io_dir <= w[11];
            io_seen <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_q <= WORD_RST;
            exec_pending <= 1'b0;
        end else begin
            exec_pending <= wr_instr;
            if (wr_instr) begin
                instr_q <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_ptr <= 8'h00;
            treg <= WORD_RST;
        end else begin
            if (wr_ram_addr) begin
                ram_ptr <= pwdata[RAM_AW-1:0];
            end
            if (wr_treg) begin
                treg <= pwdata[15:0];
            end
        end
    end

    // data ram: instruction stores, else software window
    wire exec_we = exec_pending & ram_we;
    wire [RAM_AW-1:0] ram_waddr = exec_we ? opnd_addr : ram_ptr;
    wire [WORD_W-1:0] ram_wdata = exec_we ? ram_wd : pwdata[15:0];
    always_ff @(posedge pclk) begin
        if (exec_we | wr_ram_data) begin
            data_ram[ram_waddr] <= ram_wdata;
        end
    end

    // read selection
    wire [31:0] status_word = {23'h00_0000, io_seen, io_dir, port_select_field,
                               exec_pending, illegal_flag, aux_select_pointer, page_ptr};
    wire [31:0] rd_mux =
        (paddr == OFF_INSTR) ? {16'h0000, instr_q} :
        (paddr == OFF_ACC_HI) ? {16'h0000, accum_reg[31:16]} :
        (paddr == OFF_ACC_LO) ? {16'h0000, accum_reg[15:0]} :
        (paddr == OFF_AUX0) ? {16'h0000, aux_reg_zero} :
        (paddr == OFF_AUX1) ? {16'h0000, aux_reg_one} :
        (paddr == OFF_STATUS) ? status_word :
        (paddr == OFF_RAM_ADDR) ? {24'h00_0000, ram_ptr} :
        (paddr == OFF_RAM_DATA) ? {16'h0000, data_ram[ram_ptr]} :
        (paddr == OFF_TREG) ? {16'h0000, treg} :
        (paddr == OFF_PREG) ? preg : 32'h0000_0000;

    // one wait state: ready rises in the second access cycle
    wire first_acc = bus_req & ~pready;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= first_acc;
            pslverr <= first_acc & ~addr_hit;
            if (first_acc & ~pwrite) begin
                prdata <= rd_mux;
            end
        end
    end
endmodule

// [tb/dspad_apb_host.sv]
// apb master model standing in for the host processor
`timescale 1ns/100ps
module dspad_apb_host (
    input wire logic pclk, // bus clock
    input wire logic presetn, // reset, active low
    input wire logic req, // transfer request from bench
    input wire logic wr, // request direction
    input wire logic [7:0] addr, // request address
    input wire logic [31:0] wdata, // request write data
    output logic done, // one-cycle completion
    output logic [31:0] rdata, // captured read data
    output logic err, // captured error
    output logic psel, // apb select
    output logic penable, // apb enable
    output logic pwrite, // apb direction
    output logic [7:0] paddr, // apb address
    output logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr // apb error
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {psel, penable, done, err, pwrite} <= 5'h00;
            {paddr, pwdata, rdata} <= '0;
        end else begin
            done <= 1'b0;
            if (psel && penable && pready) begin
                rdata <= prdata;
                err <= pslverr;
                psel <= 1'b0;
                penable <= 1'b0;
                done <= 1'b1;
                // released bus no longer shows the old values
                paddr <= ~paddr;
                pwdata <= ~pwdata;
            end else if (psel) begin
                penable <= 1'b1;
            end else if (req && !done) begin
                psel <= 1'b1;
                pwrite <= wr;
                paddr <= addr;
                pwdata <= wdata;
            end
        end
    end
endmodule

// [tb/dspad_core_monitor.sv]
// apb port checker for the operand addressing decoder
`timescale 1ns/100ps
module dspad_core_monitor
    import dspad_pkg::*;
(
    input wire logic pclk, // bus clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr // apb error
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire mapped = paddr <= OFF_PREG && paddr[1:0] == 2'h0;

    wait_state_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("ready not in second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    err_unmapped_a: assert property (pready && paddr > OFF_PREG |-> pslverr)
        else $error("unmapped address not refused");
    no_err_mapped_a: assert property (pready && mapped |-> !pslverr)
        else $error("mapped address refused");
    half_word_a: assert property (pready && !pwrite && mapped && paddr != OFF_PREG
        |-> prdata[31:16] == 16'h0000)
        else $error("upper half of a 16-bit register not zero");
    rdata_hold_a: assert property (!(psel && penable && !pwrite) |=> $stable(prdata))
        else $error("read data changed outside a read");

    cover property (pready && pslverr);
    cover property (pready && pwrite && paddr == OFF_INSTR);
    cover property (pready && !pwrite && paddr == OFF_ACC_LO);
endmodule

bind dspad_core dspad_core_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

// [tb/dspad_core_tb.sv]
// self-checking bench for the operand addressing decoder
`timescale 1ns/100ps
module dspad_core_tb;
    import dspad_pkg::*;
    logic pclk, presetn, req, h_wr, done, err, psel, penable, pwrite, pready, pslverr;
    logic [7:0] addr, paddr;
    logic [31:0] wdata, rdata, pwdata, prdata;
    int err_count, n_checks;

    dspad_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    dspad_apb_host u_host (.pclk(pclk), .presetn(presetn), .req(req), .wr(h_wr),
        .addr(addr), .wdata(wdata), .done(done), .rdata(rdata), .err(err), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= 1'b1;
        h_wr <= w;
        addr <= a;
        wdata <= d;
        do @(negedge pclk); while (done !== 1'b1);
        @(posedge pclk);
        req <= 1'b0;
    endtask

    task automatic get(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(rdata, exp);
    endtask

    task automatic poke(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, OFF_RAM_ADDR, {24'h000000, a});
        bus(1'b1, OFF_RAM_DATA, {16'h0000, d});
    endtask

    task automatic issue(input logic [15:0] op);
        bus(1'b1, OFF_INSTR, {16'h0000, op});
    endtask

    task automatic t_reset;
        get(OFF_ACC_LO, 32'h0);
        get(OFF_STATUS, 32'h0);
        bus(1'b0, 8'h40, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("test reset done");
    endtask

    task automatic t_direct;
        poke(8'h85, 16'h1234);
        poke(8'h06, 16'hFFFF);
        issue(16'h6E01);
        get(OFF_STATUS, 32'h1);
        issue(16'h2405);
        get(OFF_ACC_HI, 32'h0001);
        get(OFF_ACC_LO, 32'h2340);
        issue(16'h6E00);
        issue(16'h2106);
        get(OFF_ACC_HI, 32'hFFFF);
        get(OFF_ACC_LO, 32'hFFFE);
        $display("test direct done");
    endtask

    task automatic t_indirect;
        issue(16'h7085);
        issue(16'h20A8);
        get(OFF_ACC_LO, 32'h1234);
        get(OFF_AUX0, 32'h0086);
        issue(16'h6881);
        get(OFF_STATUS, 32'h2);
        issue(16'h7106);
        issue(16'h00B8);
        get(OFF_ACC_LO, 32'h1233);
        get(OFF_AUX1, 32'h0006);
        $display("test indirect done");
    endtask

    task automatic t_store;
        issue(16'h5010);
        issue(16'h5C11);
        bus(1'b1, OFF_RAM_ADDR, 32'h10);
        get(OFF_RAM_DATA, 32'h1233);
        bus(1'b1, OFF_RAM_ADDR, 32'h11);
        get(OFF_RAM_DATA, 32'h0001);
        issue(16'h7E80);
        get(OFF_ACC_LO, 32'h0080);
        issue(16'h6106);
        get(OFF_ACC_HI, 32'h0001);
        issue(16'hF000);
        get(OFF_STATUS, 32'h6);
        get(OFF_ACC_LO, 32'h007F);
        $display("test store done");
    endtask

    task automatic t_ops;
        issue(16'h7F89);
        get(OFF_ACC_LO, 32'h0);
        get(OFF_STATUS, 32'h2);
        issue(16'h6510);
        get(OFF_ACC_HI, 32'h1233);
        get(OFF_ACC_LO, 32'h0);
        issue(16'h6011);
        get(OFF_ACC_HI, 32'h1234);
        issue(16'h6210);
        get(OFF_ACC_HI, 32'h0001);
        issue(16'h6606);
        get(OFF_ACC_HI, 32'h0);
        get(OFF_ACC_LO, 32'hFFFF);
        issue(16'h6311);
        get(OFF_ACC_LO, 32'hFFFE);
        issue(16'h7910);
        get(OFF_ACC_LO, 32'h1232);
        issue(16'h7A11);
        get(OFF_ACC_LO, 32'h1233);
        issue(16'h7810);
        get(OFF_ACC_LO, 32'h0);
        issue(16'h1111);
        get(OFF_ACC_HI, 32'hFFFF);
        get(OFF_ACC_LO, 32'hFFFE);
        issue(16'h7F88);
        get(OFF_ACC_LO, 32'h2);
        issue(16'h6411);
        get(OFF_ACC_LO, 32'h4);
        issue(16'h6511);
        issue(16'h6411);
        get(OFF_ACC_HI, 32'h1);
        get(OFF_ACC_LO, 32'h1);
        issue(16'h3890);
        get(OFF_AUX0, 32'hFFFF);
        get(OFF_AUX1, 32'h5);
        get(OFF_STATUS, 32'h0);
        issue(16'h3120);
        bus(1'b1, OFF_RAM_ADDR, 32'h20);
        get(OFF_RAM_DATA, 32'h5);
        issue(16'h6F11);
        get(OFF_STATUS, 32'h1);
        issue(16'h2005);
        get(OFF_ACC_LO, 32'h1234);
        issue(16'h6E00);
        bus(1'b1, OFF_TREG, 32'h3);
        issue(16'h9FFF);
        get(OFF_PREG, 32'hFFFF_FFFD);
        issue(16'h4A00);
        get(OFF_STATUS, 32'h1A0);
        $display("test ops done");
    endtask

    initial begin
        presetn = 1'b0;
        req = 1'b0;
        h_wr = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        err_count = 0;
        n_checks = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_direct();
        t_indirect();
        t_store();
        t_ops();
        stop_test();
    end

    initial begin
        repeat (5000) @(posedge pclk);
        err_count++;
        stop_test();
    end
endmodule
